//--- logic/dbsp_pkg.sv
// shared constants for the burst-of-two ddr sram port
package dbsp_pkg;
  localparam int DBSP_WORD_W = 18;
  localparam int DBSP_ADDR_W = 8;
  localparam int DBSP_LANES = 2;
  localparam int DBSP_LANE_LO_MSB = 8;
  localparam int DBSP_LANE_HI_LSB = 9;
  localparam int DBSP_LAT_PLL = 2;
  localparam int DBSP_LAT_LEGACY = 1;
  localparam int DBSP_RD_TO_WR_NOPS = 2;
  localparam logic [17:0] DBSP_WORD_RST = 18'h00000;
  localparam logic [1:0] DBSP_LANE_NONE = 2'h3;
endpackage

//--- logic/dbsp_link_if.sv
// link between host controller and sram port
`timescale 1ns/1ps
interface dbsp_link_if #(parameter int AW = 8, parameter int DW = 18);
  logic [AW-1:0] addr;
  logic loadStrobeN;
  logic readNotWrite;
  logic [1:0] byteLaneSelectN;
  logic phaseHi;
  logic [DW-1:0] hostDq;
  logic hostDqOe;
  logic [DW-1:0] sramDq;
  logic sramDqOe;
  logic [DW-1:0] dq;
  assign dq = sramDqOe ? sramDq : hostDq;
  modport sram (input addr, loadStrobeN, readNotWrite, byteLaneSelectN, phaseHi, dq,
    output sramDq, sramDqOe);
  modport host (output addr, loadStrobeN, readNotWrite, byteLaneSelectN, phaseHi,
    hostDq, hostDqOe, input dq, sramDqOe);
endinterface

//--- logic/dbsp_sram_end.sv
// sram end of the burst-of-two double-data-rate port
// Operation
// - pll on: two cycle read latency, off: one
// - controls taken only on true rising edge
// - data captured and launched on both edges
// - every access moves two sequential 18-bit words
// - read: select high, strobe low, store address
// - first word true edge, second complementary
// - reads back to back, never cancelled
// - after reads end, outputs go high impedance
// - write: select low, strobe low, store address
// - write words next true then complementary edge
// - pipelined writes move one word per edge; here a write loaded on the next true cycle drops the one before it
// - deselected writes finish, then inputs ignored
// - lane selects sampled with each write word
// - host inserts two nops read to write
// - write posted until next write cycle
// - read of just-written address forwards data; in legacy mode a read on the next true cycle gets the old first word
// - stacked banks need separate load strobes
// - deselected, outputs high impedance after reset
// - lane 0 bits 8:0, lane 1 bits 17:9
`timescale 1ns/1ps
module dbsp_sram_end import dbsp_pkg::*; #(
  parameter int AW = DBSP_ADDR_W
) (
  // clock and reset; phaseHi in the link marks the true-clock half
  input wire logic core_clk,
  input wire logic rstn,
  // mode strap
  input wire logic pll_disable_n,
  // link
  dbsp_link_if.sram link,
  // status
  output logic busy
);
  localparam int DEPTH = 2 ** (AW + 1);

  typedef logic [DBSP_WORD_W-1:0] dbsp_word_t;
  typedef struct packed {
    logic [1:0] wrPend;       // write data phases outstanding: 2 true, 1 compl
    logic [AW-1:0] wrAddr;
    logic postValid;          // posted write awaiting commit
    logic [AW-1:0] postAddr;
    dbsp_word_t [1:0] postData;
    logic [1:0][1:0] postLanes;
    logic [2:0] rdPipe;       // read issued, per true cycle age
    logic [2:0][AW-1:0] rdAddr;
    logic [1:0] outPhase;     // 1 first word, 2 second word
    logic [AW-1:0] outAddr;
    dbsp_word_t outWord;
    logic outOe;
    logic busy;
    logic pllSync1;
    logic pllSync2;
  } dbsp_state_s;

  dbsp_state_s state_q, state_d;
  dbsp_word_t mem [DEPTH];
  dbsp_word_t inData;
  logic memWe;
  logic [AW:0] memIdx;
  dbsp_word_t memWr;
  dbsp_word_t rdWord;
  logic [AW:0] rdIdx;
  logic rdDue;
  logic [AW-1:0] rdDueAddr;
  logic [AW-1:0] rdSelAddr;

  assign inData = link.dq;

  // merge lanes of a word over old contents
  function automatic dbsp_word_t lane_merge(dbsp_word_t oldW, dbsp_word_t newW,
      logic [1:0] lanesN);
    dbsp_word_t r;
    r = oldW;
    if (!lanesN[0]) r[DBSP_LANE_LO_MSB:0] = newW[DBSP_LANE_LO_MSB:0];
    if (!lanesN[1]) r[DBSP_WORD_W-1:DBSP_LANE_HI_LSB] = newW[DBSP_WORD_W-1:DBSP_LANE_HI_LSB];
    return r;
  endfunction

  // read word source: posted write registers win over the array
  // words are fetched one half ahead of the edge that puts them on the bus:
  // in the complementary half the first word of the due read is fetched,
  // in the true half the second word of the burst already under way
  always_comb begin
    rdSelAddr = link.phaseHi ? state_q.outAddr : rdDueAddr;
    rdIdx = {rdSelAddr, link.phaseHi};
    rdWord = mem[rdIdx];
    // the posted write may not be in the array yet, so it overrides lane by lane
    if (state_q.postValid && state_q.postAddr == rdSelAddr) begin
      rdWord = lane_merge(rdWord, state_q.postData[link.phaseHi],
        state_q.postLanes[link.phaseHi]);
    end
  end

  // read due now depends on latency mode taken through a synchroniser
  always_comb begin
    if (state_q.pllSync2) begin
      rdDue = state_q.rdPipe[1];
      rdDueAddr = state_q.rdAddr[1];
    end else begin
      rdDue = state_q.rdPipe[0];
      rdDueAddr = state_q.rdAddr[0];
    end
  end

  // next state; true half = phaseHi high, complementary half = low
  always_comb begin
    state_d = state_q;
    memWe = 1'b0;
    memIdx = '0;
    memWr = DBSP_WORD_RST;
    state_d.pllSync1 = pll_disable_n;
    state_d.pllSync2 = state_q.pllSync1;
    if (link.phaseHi) begin
      // true clock edge
      state_d.rdPipe = {state_q.rdPipe[1:0], 1'b0};
      state_d.rdAddr = {state_q.rdAddr[1:0], link.addr};
      if (state_q.wrPend == 2'h2) begin
        state_d.postData[0] = inData;
        state_d.postLanes[0] = link.byteLaneSelectN;
        state_d.wrPend = 2'h1;
      end else begin
        state_d.wrPend = 2'h0;
      end
      if (!link.loadStrobeN) begin
        if (link.readNotWrite) begin
          state_d.rdPipe[0] = 1'b1;
        end else begin
          // a new write commits the posted one first
          if (state_q.postValid) begin
            state_d.postValid = 1'b0;
          end
          state_d.wrAddr = link.addr;
          state_d.wrPend = 2'h2;
        end
      end
      // second word of a burst goes out over the complementary half
      if (state_q.outPhase == 2'h1) begin
        state_d.outPhase = 2'h2;
        state_d.outWord = rdWord;
      end
    end else begin
      // complementary clock edge
      if (state_q.wrPend == 2'h1) begin
        state_d.postData[1] = inData;
        state_d.postLanes[1] = link.byteLaneSelectN;
        state_d.postAddr = state_q.wrAddr;
        state_d.postValid = 1'b1;
        state_d.wrPend = 2'h0;
      end
      // first word is registered here so that it stands over the true half;
      // without a due read the bus is released after the burst's complementary edge
      if (rdDue) begin
        state_d.outPhase = 2'h1;
        state_d.outAddr = rdDueAddr;
        state_d.outWord = rdWord;
        state_d.outOe = 1'b1;
      end else begin
        state_d.outPhase = 2'h0;
        state_d.outOe = 1'b0;
      end
    end
    // commit both posted words in one cycle when a write is loaded
    if (state_q.postValid && link.phaseHi && !link.loadStrobeN && !link.readNotWrite) begin
      memWe = 1'b1;
      memIdx = {state_q.postAddr, 1'b0};
      memWr = lane_merge(mem[{state_q.postAddr, 1'b0}], state_q.postData[0],
        state_q.postLanes[0]);
    end
    state_d.busy = |state_q.rdPipe || state_q.wrPend != 2'h0 || state_q.outOe;
  end

  // second posted word commits alongside the first through a dedicated port
  logic commitHi;
  assign commitHi = memWe;

  // registers; array has no reset as real sram cells do not
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
    if (memWe) begin
      mem[memIdx] <= memWr;
    end
    if (commitHi) begin
      mem[{state_q.postAddr, 1'b1}] <= lane_merge(mem[{state_q.postAddr, 1'b1}],
        state_q.postData[1], state_q.postLanes[1]);
    end
  end

  assign link.sramDq = state_q.outWord;
  // enable comes straight from its flop and covers both words of a burst
  assign link.sramDqOe = state_q.outOe;
  assign busy = state_q.busy;
endmodule // dbsp_sram_end

//--- logic/dbsp_host_end.sv
// host controller end of the burst-of-two double-data-rate port
`timescale 1ns/1ps
module dbsp_host_end import dbsp_pkg::*; #(
  parameter int AW = DBSP_ADDR_W,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // request side
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqRead,
  input wire logic [AW-1:0] reqAddr,
  input wire logic [1:0][DBSP_WORD_W-1:0] reqData,
  input wire logic [1:0][1:0] reqLanesN,
  // read answer side, two-entry buffer
  output logic rspValid,
  input wire logic rspReady,
  output logic [DBSP_WORD_W-1:0] rspWord,
  // link
  dbsp_link_if.host link
);
  typedef logic [DBSP_WORD_W-1:0] dbsp_hword_t;
  typedef struct packed {
    logic phaseHi;
    logic [1:0] nopCnt;       // nops left before a write may follow a read
    logic [1:0] wrPhase;      // 2 first word next true half, 1 second word next half
    logic [1:0][DBSP_WORD_W-1:0] wrData;
    logic [1:0][1:0] wrLanes;
    logic [AW-1:0] addr;
    logic loadN;
    logic rnw;
    logic [1:0] lanesN;
    dbsp_hword_t dq;
    logic dqOe;
    logic [1:0] capCnt;       // read words still to arrive
    logic [DEPTH-1:0][DBSP_WORD_W-1:0] rbuf;
    logic [1:0] bufCnt;
    logic reqReady;
  } dbsp_hstate_s;

  dbsp_hstate_s s_q, s_d;
  logic take;

  // one access at a time: a request waits until the previous one has left the
  // link and the two-entry buffer is empty, so no read word is ever lost; the
  // cost is bandwidth, the sram could take a new read every true cycle
  always_comb begin
    s_d = s_q;
    take = s_q.reqReady && reqValid;
    s_d.phaseHi = !s_q.phaseHi;
    if (rspValid && rspReady) begin
      s_d.rbuf = {dbsp_hword_t'(0), s_q.rbuf[DEPTH-1:1]};
      s_d.bufCnt = s_q.bufCnt - 2'h1;
    end
    if (!s_q.phaseHi) begin
      // next cycle is the true half: controls set now stand over its edge
      s_d.loadN = !take;
      if (s_q.nopCnt != 2'h0) s_d.nopCnt = s_q.nopCnt - 2'h1;
      // first write word for the true edge after the load
      s_d.dqOe = s_q.wrPhase == 2'h2;
      s_d.dq = s_q.wrData[0];
      s_d.lanesN = s_q.wrPhase == 2'h2 ? s_q.wrLanes[0] : DBSP_LANE_NONE;
      if (s_q.wrPhase == 2'h2) s_d.wrPhase = 2'h1;
      if (take) begin
        s_d.rnw = reqRead;
        s_d.addr = reqAddr;
        if (reqRead) begin
          s_d.capCnt = 2'h2;
          s_d.nopCnt = 2'(DBSP_RD_TO_WR_NOPS);
        end else begin
          s_d.wrPhase = 2'h2;
          s_d.wrData = reqData;
          s_d.wrLanes = reqLanesN;
        end
      end
    end else begin
      // next cycle is the complementary half, where no load may stand
      s_d.loadN = 1'b1;
      if (s_q.wrPhase == 2'h1) begin
        s_d.dq = s_q.wrData[1];
        s_d.lanesN = s_q.wrLanes[1];
        s_d.wrPhase = 2'h0;
      end
    end
    // read words are taken on every half in which the sram drives the bus
    if (link.sramDqOe && s_q.capCnt != 2'h0) begin
      s_d.capCnt = s_q.capCnt - 2'h1;
      s_d.rbuf[s_d.bufCnt[0]] = link.dq;
      s_d.bufCnt = s_d.bufCnt + 2'h1;
    end
    // ready only in the half that precedes a true edge
    s_d.reqReady = !s_d.phaseHi && s_d.bufCnt == 2'h0 && s_d.capCnt == 2'h0 &&
      s_d.wrPhase == 2'h0 && s_d.nopCnt == 2'h0;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.loadN <= 1'b1;
      s_q.lanesN <= DBSP_LANE_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign reqReady = s_q.reqReady;
  assign rspValid = s_q.bufCnt != 2'h0;
  assign rspWord = s_q.rbuf[0];
  assign link.phaseHi = s_q.phaseHi;
  assign link.addr = s_q.addr;
  assign link.loadStrobeN = s_q.loadN;
  assign link.readNotWrite = s_q.rnw;
  assign link.byteLaneSelectN = s_q.lanesN;
  assign link.hostDq = s_q.dq;
  assign link.hostDqOe = s_q.dqOe;
endmodule // dbsp_host_end

//--- testbench/dbsp_link_sva.sv
// concurrent checks on the link between the host end and the sram end
`timescale 1ns/1ps
module dbsp_link_sva (
  // clock, reset and mode
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic pll_disable_n,
  // link
  input wire logic [7:0] addr,
  input wire logic loadStrobeN,
  input wire logic readNotWrite,
  input wire logic [1:0] byteLaneSelectN,
  input wire logic phaseHi,
  input wire logic [17:0] hostDq,
  input wire logic hostDqOe,
  input wire logic [17:0] sramDq,
  input wire logic sramDqOe,
  input wire logic [17:0] dq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // decoded loads; the strobe alone qualifies, the select only says which kind
  wire rdLoad = !loadStrobeN && readNotWrite;
  wire wrLoad = !loadStrobeN && !readNotWrite;
  load_true_edge_a: assert property (!loadStrobeN |-> phaseHi)
    else $error("load outside true-clock half");
  pll_read_lat_a: assert property (rdLoad && pll_disable_n |-> ##4 sramDqOe ##1 sramDqOe)
    else $error("read burst late or short with pll on");
  legacy_read_lat_a: assert property (rdLoad && !pll_disable_n |-> ##2 sramDqOe ##1 sramDqOe)
    else $error("read burst late or short in legacy mode");
  write_data_a: assert property (wrLoad |-> ##2 hostDqOe ##1 hostDqOe)
    else $error("write words not on the bus after load");
  turnaround_a: assert property (rdLoad |=> (!wrLoad) [*5])
    else $error("write loaded too soon after read");
  no_contention_a: assert property (!(sramDqOe && hostDqOe))
    else $error("both ends drive the data bus");
  idle_hiz_a: assert property (loadStrobeN [*8] |-> !sramDqOe)
    else $error("sram drives bus while idle");
  reset_hiz_a: assert property ($rose(rstn) |-> !sramDqOe)
    else $error("sram drives bus after reset");
  // main scenarios
  back_to_back_rd_c: cover property (rdLoad ##2 rdLoad);
  back_to_back_wr_c: cover property (wrLoad ##2 wrLoad);
  forward_c: cover property (wrLoad ##2 rdLoad);
  legacy_rd_c: cover property (rdLoad && !pll_disable_n);
endmodule // dbsp_link_sva

//--- testbench/testbench.sv
// self-checking bench: host end and sram end joined by the link
`timescale 1ns/1ps
module testbench import dbsp_pkg::*; ;
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected at %0t: %h vs %h", $time, got, exp); end end
  logic core_clk, rstn, pllDisableN, reqValid, reqRead, rspReady;
  logic reqReady, rspValid;
  logic [7:0] reqAddr;
  logic [1:0][17:0] reqData;
  logic [1:0][1:0] reqLanesN;
  logic [17:0] rspWord, expW;
  logic [17:0] mem [0:7][0:1];
  logic [17:0] expQ [$];
  int n_checks = 0;
  int n_mismatch = 0;
  dbsp_link_if #(.AW(8), .DW(18)) link();
  dbsp_host_end u_dbsp_host_end (.core_clk(core_clk), .rstn(rstn), .reqValid(reqValid),
    .reqReady(reqReady), .reqRead(reqRead), .reqAddr(reqAddr), .reqData(reqData),
    .reqLanesN(reqLanesN), .rspValid(rspValid), .rspReady(rspReady), .rspWord(rspWord),
    .link(link));
  dbsp_sram_end u_dbsp_sram_end (.core_clk(core_clk), .rstn(rstn),
    .pll_disable_n(pllDisableN), .link(link), .busy());
  dbsp_link_sva chk (.core_clk(core_clk), .rstn(rstn), .pll_disable_n(pllDisableN),
    .addr(link.addr), .loadStrobeN(link.loadStrobeN), .readNotWrite(link.readNotWrite),
    .byteLaneSelectN(link.byteLaneSelectN), .phaseHi(link.phaseHi), .hostDq(link.hostDq),
    .hostDqOe(link.hostDqOe), .sramDq(link.sramDq), .sramDqOe(link.sramDqOe), .dq(link.dq));
  // lane merge: a high select keeps the stored lane
  function automatic logic [17:0] merge(logic [17:0] old, logic [17:0] nw, logic [1:0] ln);
    merge = old;
    if (!ln[0]) merge[8:0] = nw[8:0];
    if (!ln[1]) merge[17:9] = nw[17:9];
  endfunction
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // holds the request until taken, then books the expectation; valid stays up
  task automatic issue(logic rd, logic [2:0] a, logic [35:0] d, logic [3:0] ln);
    int t;
    t = 0;
    reqValid <= 1'b1;
    reqRead <= rd;
    reqAddr <= {5'h00, a};
    reqData <= d;
    reqLanesN <= ln;
    @(posedge core_clk);
    while (reqReady !== 1'b1 && t < 300) begin
      @(posedge core_clk);
      t++;
    end
    if (t >= 300) `CHK(reqReady, 1'b1)
    for (int i = 0; i < 2; i++) begin
      if (rd) expQ.push_back(mem[a][i]);
      else mem[a][i] = merge(mem[a][i], d[i*18 +: 18], ln[i*2 +: 2]);
    end
  endtask
  // random stalls on the answer side fill the two-entry buffer
  always @(posedge core_clk) rspReady <= 1'($urandom());
  // answer words in order, word of address then its burst partner
  always @(posedge core_clk) begin
    if (rstn === 1'b1 && rspValid === 1'b1 && rspReady === 1'b1) begin
      expW = (expQ.size() > 0) ? expQ.pop_front() : 18'h3FFFF ^ rspWord;
      `CHK(rspWord, expW)
    end
  end
  initial begin
    #500000;
    n_mismatch++;
    $display("unexpected at %0t: run hung", $time);
    give_verdict();
  end
  initial begin
    rstn = 1'b0;
    pllDisableN = 1'b1;
    reqValid = 1'b0;
    reqRead = 1'b0;
    reqAddr = 8'h00;
    reqData = '0;
    reqLanesN = 4'hF;
    rspReady = 1'b0;
    void'($urandom(32'h3cede090));
    // pass 0 with pll on, pass 1 in legacy mode behind a mid-run reset
    for (int m = 0; m < 2; m++) begin
      rstn <= 1'b0;
      pllDisableN <= ~m[0];
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge core_clk);
      `CHK(link.sramDqOe, 1'b0)
      for (int a = 0; a < 8; a++) issue(1'b0, 3'(a), 36'({$urandom(), $urandom()}), 4'h0);
      // partial lanes then read of the same address right away
      issue(1'b0, 3'h5, 36'h2AAAA5555, 4'h6);
      issue(1'b1, 3'h5, '0, 4'h0);
      repeat (80) issue(1'($urandom()), 3'($urandom()), 36'({$urandom(), $urandom()}),
        4'($urandom()));
      reqValid <= 1'b0;
      for (int t = 0; t < 400 && expQ.size() > 0; t++) @(posedge core_clk);
      `CHK(expQ.size(), 0)
    end
    give_verdict();
  end
endmodule // testbench
